// >>> core/flash_status_protect_config.sv
/*
 * Status, protection and read-latency configuration bank of a serial
 * NOR flash, with a mode-0 serial front end on the link clock.
 * Assumes the host raises chip select between commands, busy comes from
 * the array engine on core_clk, and reset marks a power cycle.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_regs.svh"

module flash_status_protect_config
    import flash_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       spi_clk,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       wp_n,
    input  wire logic       busy,
    output var  logic       so_r,
    output var  logic       so_oe_n_r,
    output var  logic       quad_lines_r,
    output var  logic [3:0] lock_out_r,
    output var  logic       suspend_out_r,
    output var  logic [3:0] fast_dummy_r,
    output var  logic [3:0] dual_io_dummy_r,
    output var  logic [3:0] quad_io_dummy_r
);

    // ============================================================
    // Link side: byte assembly and status shift-out
    logic       link_rst;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [6:0] shift_r, shift_nxt;
    logic [7:0] byte_hold_r, byte_hold_nxt;
    logic       byte_tgl_r, byte_tgl_nxt;
    logic       first_done_r, first_done_nxt;
    logic [7:0] link_op_r, link_op_nxt;
    logic [7:0] pub_low_r, pub_high_r, pub_cfg_r;
    logic [7:0] out_byte;
    logic       out_valid;

    // Chip select high clears the frame state; reset is a constant load
    assign link_rst = reset | cs_n;

    // Next values of the receive side; sample on rising edge (mode 0)
    always_comb begin
        bit_cnt_nxt    = bit_cnt_r + 3'h1;
        shift_nxt      = {shift_r[5:0], si};
        byte_hold_nxt  = byte_hold_r;
        byte_tgl_nxt   = byte_tgl_r;
        first_done_nxt = first_done_r;
        link_op_nxt    = link_op_r;
        if (bit_cnt_r == 3'h7) begin
            byte_hold_nxt  = {shift_r, si};
            byte_tgl_nxt   = ~byte_tgl_r;
            first_done_nxt = 1'b1;
            if (!first_done_r) begin
                link_op_nxt = {shift_r, si};
            end
        end
    end

    always_ff @(posedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_r    <= 3'h0;
            shift_r      <= 7'h00;
            first_done_r <= 1'b0;
            link_op_r    <= 8'h00;
        end else begin
            bit_cnt_r    <= bit_cnt_nxt;
            shift_r      <= shift_nxt;
            first_done_r <= first_done_nxt;
            link_op_r    <= link_op_nxt;
        end
    end

    // Hold and toggle survive frame end so the core can still read them
    always_ff @(posedge spi_clk or posedge reset) begin
        if (reset) begin
            byte_hold_r <= 8'h00;
            byte_tgl_r  <= 1'b0;
        end else begin
            byte_hold_r <= byte_hold_nxt;
            byte_tgl_r  <= byte_tgl_nxt;
        end
    end

    // Published bytes are frozen while a frame runs, so reading them
    // here is a safe word crossing; status reads repeat the same byte
    always_comb begin
        out_valid = first_done_r;
        case (link_op_r)
            `OP_READ_LOW:    out_byte = pub_low_r;
            `OP_READ_HIGH:   out_byte = pub_high_r;
            `OP_READ_CONFIG: out_byte = pub_cfg_r;
            default: begin
                out_byte  = 8'h00;
                out_valid = 1'b0;
            end
        endcase
    end

    // Shift out on the falling edge; enable low while driving
    always_ff @(negedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            so_r      <= 1'b0;
            so_oe_n_r <= 1'b1;
        end else begin
            so_r      <= out_byte[3'h7 - bit_cnt_r];
            so_oe_n_r <= ~out_valid;
        end
    end

    // ============================================================
    // Core side: synchronisers (three stages, second and third agree)
    logic [2:0] cs_sync_r, tgl_sync_r, wp_sync_r;
    logic       cs_q_r, tgl_seen_r, wp_q_r;
    logic       cs_q_nxt, tgl_seen_nxt, wp_q_nxt;
    logic       frame_end, frame_start, byte_in;

    always_comb begin
        cs_q_nxt     = (cs_sync_r[1] == cs_sync_r[2]) ? cs_sync_r[2] : cs_q_r;
        wp_q_nxt     = (wp_sync_r[1] == wp_sync_r[2]) ? wp_sync_r[2] : wp_q_r;
        byte_in      = (tgl_sync_r[1] == tgl_sync_r[2]) &&
                       (tgl_sync_r[2] != tgl_seen_r);
        tgl_seen_nxt = byte_in ? tgl_sync_r[2] : tgl_seen_r;
        frame_end    = cs_q_nxt & ~cs_q_r;
        frame_start  = ~cs_q_nxt & cs_q_r;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cs_sync_r  <= 3'h7;
            tgl_sync_r <= 3'h0;
            wp_sync_r  <= 3'h0;
            cs_q_r     <= 1'b1;
            tgl_seen_r <= 1'b0;
            wp_q_r     <= 1'b0;
        end else begin
            cs_sync_r  <= {cs_sync_r[1:0], cs_n};
            tgl_sync_r <= {tgl_sync_r[1:0], byte_tgl_r};
            wp_sync_r  <= {wp_sync_r[1:0], wp_n};
            cs_q_r     <= cs_q_nxt;
            tgl_seen_r <= tgl_seen_nxt;
            wp_q_r     <= wp_q_nxt;
        end
    end

    // ============================================================
    // Core side: command capture and register bank
    logic [7:0] op_r, op_nxt, d1_r, d1_nxt, d2_r, d2_nxt, d3_r, d3_nxt;
    logic [2:0] nbytes_r, nbytes_nxt;
    // Non-volatile storage starts at the factory state; no reset
    logic [5:0] nv_low_r = `NV_LOW_RST;
    logic [2:0] nv_high_r = `NV_HIGH_RST;
    logic [3:0] lock_r = `LOCK_RST;
    logic [5:0] nv_low_nxt, v_low_r, v_low_nxt;
    logic [2:0] nv_high_nxt, v_high_r, v_high_nxt;
    logic [3:0] lock_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic       wel_r, wel_nxt, vol_sel_r, vol_sel_nxt;
    logic       sus_r, sus_nxt, rst_arm_r, rst_arm_nxt;
    logic       loaded_r, loaded_nxt;
    protect_mode_t mode;
    logic       wp_eff, locked;
    logic [7:0] low_byte, high_byte;

    // Status bytes as the host sees them (volatile copies; lock bits straight from storage)
    always_comb begin
        low_byte  = {v_low_r, wel_r, busy};
        high_byte = {sus_r, v_high_r[2], lock_r, v_high_r[1], v_high_r[0]};
        mode      = protect_mode_t'({v_high_r[0], v_low_r[5]});
        wp_eff    = v_high_r[1] | wp_q_r;   // Quad lines drop the pin
        case (mode)
            PM_SOFTWARE: locked = 1'b0;
            PM_HARDWARE: locked = ~wp_eff;
            PM_LOCKDOWN: locked = 1'b1;
            default:     locked = 1'b1;
        endcase
    end

    // Next register values; commands act when chip select rises
    always_comb begin
        op_nxt      = op_r;
        d1_nxt      = d1_r;
        d2_nxt      = d2_r;
        d3_nxt      = d3_r;
        nbytes_nxt  = nbytes_r;
        nv_low_nxt  = nv_low_r;
        nv_high_nxt = nv_high_r;
        v_low_nxt   = v_low_r;
        v_high_nxt  = v_high_r;
        lock_nxt    = lock_r;
        cfg_nxt     = cfg_r;
        wel_nxt     = wel_r;
        vol_sel_nxt = vol_sel_r;
        sus_nxt     = sus_r;
        rst_arm_nxt = rst_arm_r;
        loaded_nxt  = 1'b1;
        if (frame_start) begin
            nbytes_nxt = 3'h0;
        end
        if (byte_in && nbytes_r != 3'h7) begin
            nbytes_nxt = nbytes_r + 3'h1;
            case (nbytes_r)
                3'h0:    op_nxt = byte_hold_r;
                3'h1:    d1_nxt = byte_hold_r;
                3'h2:    d2_nxt = byte_hold_r;
                3'h3:    d3_nxt = byte_hold_r;
                default: op_nxt = op_r;
            endcase
        end
        // First cycle after power-up: volatile copies load from storage
        if (!loaded_r) begin
            v_low_nxt  = nv_low_r;
            v_high_nxt = nv_high_r;
        end else if (frame_end && nbytes_r != 3'h0) begin
            rst_arm_nxt = 1'b0;
            case (op_r)
                `OP_WRITE_ENABLE: begin
                    wel_nxt     = 1'b1;
                    vol_sel_nxt = 1'b0;
                end
                `OP_VOL_WR_ENABLE: begin
                    wel_nxt     = 1'b1;
                    vol_sel_nxt = 1'b1;
                end
                `OP_WRITE_DISABLE: begin
                    wel_nxt = 1'b0;
                end
                `OP_SUSPEND: sus_nxt = 1'b1;
                `OP_RESUME:  sus_nxt = 1'b0;
                `OP_RESET_ENABLE: rst_arm_nxt = 1'b1;
                `OP_RESET: begin
                    if (rst_arm_r) begin
                        // Software reset reloads volatile state
                        wel_nxt     = 1'b0;
                        vol_sel_nxt = 1'b0;
                        sus_nxt     = 1'b0;
                        cfg_nxt     = `CONFIG_RST;
                        v_low_nxt   = nv_low_r;
                        v_high_nxt  = nv_high_r;
                        if (mode == PM_LOCKDOWN) begin
                            v_low_nxt[5]   = 1'b0;
                            v_high_nxt[0]  = 1'b0;
                            nv_low_nxt[5]  = 1'b0;
                            nv_high_nxt[0] = 1'b0;
                        end
                    end
                end
                `OP_WRITE_STATUS: begin
                    // Judged at completion; a protected write drops its status bytes, a volatile config byte still loads
                    if (wel_r && !locked) begin
                        if (nbytes_r >= 3'h2) begin
                            v_low_nxt = d1_r[7:2];
                            if (!vol_sel_r) begin
                                nv_low_nxt = d1_r[7:2];
                            end
                        end
                        if (nbytes_r >= 3'h3) begin
                            v_high_nxt = {d2_r[6], d2_r[1:0]};
                            if (!vol_sel_r) begin
                                nv_high_nxt = {d2_r[6], d2_r[1:0]};
                                lock_nxt = lock_r | d2_r[5:2];
                            end
                        end
                    end
                    if (wel_r && vol_sel_r && nbytes_r >= 3'h4) begin
                        cfg_nxt = d3_r;
                    end
                    wel_nxt     = 1'b0;
                    vol_sel_nxt = 1'b0;
                end
                default: rst_arm_nxt = 1'b0;
            endcase
        end
    end

    // Power-up clears lock-down in storage; constants only under reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            op_r      <= 8'h00;
            d1_r      <= 8'h00;
            d2_r      <= 8'h00;
            d3_r      <= 8'h00;
            nbytes_r  <= 3'h0;
            v_low_r   <= `NV_LOW_RST;
            v_high_r  <= `NV_HIGH_RST;
            cfg_r     <= `CONFIG_RST;
            wel_r     <= 1'b0;
            vol_sel_r <= 1'b0;
            sus_r     <= 1'b0;
            rst_arm_r <= 1'b0;
            loaded_r  <= 1'b0;
        end else begin
            op_r      <= op_nxt;
            d1_r      <= d1_nxt;
            d2_r      <= d2_nxt;
            d3_r      <= d3_nxt;
            nbytes_r  <= nbytes_nxt;
            v_low_r   <= v_low_nxt;
            v_high_r  <= v_high_nxt;
            cfg_r     <= cfg_nxt;
            wel_r     <= wel_nxt;
            vol_sel_r <= vol_sel_nxt;
            sus_r     <= sus_nxt;
            rst_arm_r <= rst_arm_nxt;
            loaded_r  <= loaded_nxt;
        end
    end

    // Non-volatile storage: no reset, so it survives a power cycle, except that power-up clears a lock-down mode pair
    always_ff @(posedge core_clk) begin
        if (!loaded_r && {nv_high_r[0], nv_low_r[5]} == 2'b10) begin
            nv_low_r  <= {1'b0, nv_low_r[4:0]};
            nv_high_r <= {nv_high_r[2:1], 1'b0};
        end else begin
            nv_low_r  <= nv_low_nxt;
            nv_high_r <= nv_high_nxt;
        end
        lock_r <= lock_nxt;
    end

    // ============================================================
    // Published copies and outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pub_low_r       <= 8'h00;
            pub_high_r      <= 8'h00;
            pub_cfg_r       <= 8'h00;
            quad_lines_r    <= 1'b0;
            lock_out_r      <= 4'h0;
            suspend_out_r   <= 1'b0;
            fast_dummy_r    <= `LEGACY_FAST_DUMMY;
            dual_io_dummy_r <= `LEGACY_DUAL_IO_DUMMY;
            quad_io_dummy_r <= `LEGACY_QUAD_IO_DUMMY;
        end else begin
            // Only refreshed between frames so the link sees a still word
            if (cs_q_r) begin
                pub_low_r  <= low_byte;
                pub_high_r <= high_byte;
                pub_cfg_r  <= cfg_r;
            end
            quad_lines_r  <= v_high_r[1];
            lock_out_r    <= lock_r;
            suspend_out_r <= sus_r;
            // Plain read uses none of these; mode bits are extra
            fast_dummy_r    <= (cfg_r[3:0] == 4'h0) ?
                               `LEGACY_FAST_DUMMY : cfg_r[3:0];
            dual_io_dummy_r <= (cfg_r[3:0] == 4'h0) ?
                               `LEGACY_DUAL_IO_DUMMY : cfg_r[3:0];
            quad_io_dummy_r <= (cfg_r[3:0] == 4'h0) ?
                               `LEGACY_QUAD_IO_DUMMY : cfg_r[3:0];
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_lock_sticky: assert property (
        loaded_r |=> ((lock_r & ~$past(lock_r)) == lock_r) ||
                     (($past(lock_r) & ~lock_r) == 4'h0))
        else $error("lock bit cleared");
    a_lock_zero_set: assert property (
        lock_r[0])
        else $error("lock bit 0 not set");
    a_locked_no_write: assert property (
        loaded_r && frame_end && op_r == `OP_WRITE_STATUS && locked
        |=> v_low_r == $past(v_low_r) && v_high_r == $past(v_high_r))
        else $error("protected status write took effect");
    a_soft_write_ok: assert property (
        loaded_r && frame_end && op_r == `OP_WRITE_STATUS && wel_r &&
        mode == PM_SOFTWARE && nbytes_r >= 3'h2
        |=> v_low_r == $past(d1_r[7:2]))
        else $error("unprotected status write lost");
    a_status_ro: assert property (
        loaded_r && frame_end && op_r == `OP_WRITE_STATUS
        |=> sus_r == $past(sus_r) && !wel_r)
        else $error("read-only status bit changed");
    a_vol_keeps_lock: assert property (
        loaded_r && frame_end && op_r == `OP_WRITE_STATUS && vol_sel_r
        |=> lock_r == $past(lock_r))
        else $error("volatile write changed lock bits");
    a_suspend_set: assert property (
        loaded_r && frame_end && nbytes_r != 3'h0 && op_r == `OP_SUSPEND
        |=> sus_r ##1 suspend_out_r)
        else $error("suspend flag not set");
    a_lockdown_leave: assert property (
        loaded_r && frame_end && op_r == `OP_RESET && rst_arm_r &&
        mode == PM_LOCKDOWN |=> mode == PM_SOFTWARE)
        else $error("lock-down survived software reset");
    a_fast_latency: assert property (
        loaded_r ##1 $stable(cfg_r) |=> fast_dummy_r ==
        (($past(cfg_r[3:0]) == 4'h0) ? `LEGACY_FAST_DUMMY :
         $past(cfg_r[3:0])))
        else $error("fast read latency wrong");

    c_write_taken: cover property (
        frame_end && op_r == `OP_WRITE_STATUS && wel_r && !locked);
    c_write_refused: cover property (
        frame_end && op_r == `OP_WRITE_STATUS && wel_r && locked);
    c_suspend: cover property (frame_end && op_r == `OP_SUSPEND);
    c_lockdown_reset: cover property (
        frame_end && op_r == `OP_RESET && mode == PM_LOCKDOWN);

endmodule : flash_status_protect_config
`default_nettype wire

// >>> inc/flash_status_regs.svh
/*
 * Opcodes, reset values and latency figures of the
 * status and configuration register bank of a serial NOR flash.
 * Assumes it is included once by the bank and by its bench.
 */
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

// ============================================================
// Command opcodes
`define OP_WRITE_STATUS   8'h01
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_VOL_WR_ENABLE  8'h50
`define OP_SUSPEND        8'h75
`define OP_RESUME         8'h7A
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_READ_LOW       8'h05
`define OP_READ_HIGH      8'h35
`define OP_READ_CONFIG    8'h15

// ============================================================
// Non-volatile reset values (factory state) and the volatile config reset value
`define NV_LOW_RST        6'h00
`define NV_HIGH_RST       3'h0
`define LOCK_RST          4'h1
`define CONFIG_RST        8'h00

// ============================================================
// Latency figures in serial clocks
`define LEGACY_FAST_DUMMY    4'h8
`define LEGACY_DUAL_IO_DUMMY 4'h0
`define LEGACY_QUAD_IO_DUMMY 4'h4
`define DUAL_IO_MODE_BITS    4'h4

`endif

// >>> inc/flash_status_pkg.sv
/*
 * Types shared by the status register bank and its bench.
 * Assumes nothing of its surroundings.
 */
package flash_status_pkg;
    // Protect-mode pair {upper, lower}
    typedef enum logic [1:0] {
        PM_SOFTWARE = 2'b00,
        PM_HARDWARE = 2'b01,
        PM_OTP      = 2'b11,
        PM_LOCKDOWN = 2'b10
    } protect_mode_t;
endpackage : flash_status_pkg

// >>> test/spi_host_model.sv
/*
 * Host serial controller model: mode-0 frames of whole bytes.
 * Assumes the bank samples si on the rising edge and drives so on the fall.
 */
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    output var  logic spi_clk,
    output var  logic cs_n,
    output var  logic si,
    input  wire logic so
);
    // ============================================================
    // Frame engine
    // 160 ns period keeps far below the read clock ceiling
    localparam int HALF = 80;

    initial begin
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
    end

    // Sends nb bytes from the top of bits; second byte slot is captured
    task automatic frame(input logic [31:0] bits, input int nb,
                         output logic [7:0] rx);
        int i;
        #3;
        cs_n = 1'b0;
        for (i = 0; i < nb * 8; i++) begin
            si = bits[31 - i];
            #HALF spi_clk = 1'b1;
            if (i >= 8 && i < 16) begin
                rx = {rx[6:0], so};
            end
            #HALF spi_clk = 1'b0;
        end
        // Released line must not keep showing the last bit
        si = ~si;
        #HALF cs_n = 1'b1;
        // Gap covers the core-side sync of the chip-select rise
        #400;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> test/flash_status_protect_config_test.sv
/*
 * Self-checking bench of the status and protection bank.
 * Assumes the host model file is compiled first; keeps its own model.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_regs.svh"

module flash_status_protect_config_test;
    import flash_status_pkg::*;
    logic        core_clk, reset, wp_n, busy, so_r, so_oe_n_r;
    logic        quad_lines_r, suspend_out_r, suspend_flag;
    logic [3:0]  lock_out_r, fast_dummy_r, dual_io_dummy_r, quad_io_dummy_r;
    logic [7:0]  nv_lo, nv_hi, v_lo, v_hi, cfg, rx;
    logic [31:0] seed;
    wire logic   spi_clk, cs_n, si;
    int          n_fail, n_compared, cyc, i, k;

    flash_status_protect_config dut_u (.core_clk(core_clk), .reset(reset),
        .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .busy(busy),
        .so_r(so_r), .so_oe_n_r(so_oe_n_r), .quad_lines_r(quad_lines_r),
        .lock_out_r(lock_out_r), .suspend_out_r(suspend_out_r),
        .fast_dummy_r(fast_dummy_r), .dual_io_dummy_r(dual_io_dummy_r),
        .quad_io_dummy_r(quad_io_dummy_r));
    spi_host_model host_u (.spi_clk(spi_clk), .cs_n(cs_n), .si(si),
        .so(so_r));

    // ============================================================
    // Clock and hang guard
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            stop_test();
        end
    end

    // ============================================================
    // Expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] dummy(input logic [3:0] lc, legacy);
        return {4'h0, (lc == 4'h0) ? legacy : lc};
    endfunction : dummy
    // Quad enable turns the pin into data, so it reads as released high
    function automatic logic may_write(input logic [7:0] lo, hi,
                                       input logic wp);
        case (protect_mode_t'({hi[0], lo[7]}))
            PM_SOFTWARE: return 1'b1;
            PM_HARDWARE: return wp | hi[1];
            default:     return 1'b0;
        endcase
    endfunction : may_write

    task automatic chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op);
        host_u.frame({op, 24'h0}, 1, rx);
    endtask : cmd
    // Write enable, then the status write; the model mirrors the outcome
    task automatic wrs(input logic vol, input logic [7:0] b0, b1, b2,
                       input int nb);
        cmd(vol ? `OP_VOL_WR_ENABLE : `OP_WRITE_ENABLE);
        host_u.frame({`OP_WRITE_STATUS, b0, b1, b2}, nb + 1, rx);
        if (may_write(v_lo, v_hi, wp_n)) begin
            v_lo[7:2] = b0[7:2];
            if (nb >= 2) {v_hi[6], v_hi[1:0]} = {b1[6], b1[1:0]};
            if (!vol) begin
                nv_lo[7:2] = b0[7:2];
                if (nb >= 2) nv_hi[6:0] = {b1[6], nv_hi[5:2] | b1[5:2],
                                           b1[1:0]};
            end
        end
        if (vol && nb >= 3) cfg = b2;
    endtask : wrs
    task automatic model_reset();
        if ({nv_hi[0], nv_lo[7]} == PM_LOCKDOWN) begin
            nv_hi[0] = 1'b0;
            nv_lo[7] = 1'b0;
        end
        v_lo = nv_lo;
        v_hi = nv_hi;
        cfg  = 8'h00;
        suspend_flag  = 1'b0;
    endtask : model_reset
    task automatic power_cycle();
        @(posedge core_clk) #1 reset = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        model_reset();
        repeat (8) @(posedge core_clk);
    endtask : power_cycle
    task automatic chk_all();
        host_u.frame({`OP_READ_LOW, 24'h0}, 2, rx);
        chk("low", {v_lo[7:2], 1'b0, busy}, rx);
        host_u.frame({`OP_READ_HIGH, 24'h0}, 2, rx);
        chk("high", {suspend_flag, v_hi[6], nv_hi[5:2], v_hi[1:0]}, rx);
        host_u.frame({`OP_READ_CONFIG, 24'h0}, 2, rx);
        chk("config", cfg, rx);
        chk("lock", {4'h0, nv_hi[5:2]}, {4'h0, lock_out_r});
        chk("quad", {7'h0, v_hi[1]}, {7'h0, quad_lines_r});
        chk("susp", {7'h0, suspend_flag}, {7'h0, suspend_out_r});
        chk("fast", dummy(cfg[3:0], `LEGACY_FAST_DUMMY),
            {4'h0, fast_dummy_r});
        chk("dualio", dummy(cfg[3:0], `LEGACY_DUAL_IO_DUMMY),
            {4'h0, dual_io_dummy_r});
        chk("quadio", dummy(cfg[3:0], `LEGACY_QUAD_IO_DUMMY),
            {4'h0, quad_io_dummy_r});
        chk("oe_idle", 8'h01, {7'h0, so_oe_n_r});
    endtask : chk_all
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // ============================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        wp_n = 1'b1;
        busy = 1'b0;
        seed = 32'hDA46;
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        nv_lo = 8'h00;
        nv_hi = 8'h04;
        power_cycle();
        chk_all();
        // Volatile writes with random fields; latency corners 15 and 0
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            @(posedge core_clk) #1 busy = seed[0];
            wrs(1'b1, {1'b0, seed[6:2], 2'b11}, {1'b1, seed[14], 6'h3C},
                (i == 0) ? 8'h0F : (i == 1) ? 8'h00 : seed[23:16],
                3);
            chk_all();
        end
        // Latch cleared by write disable: the write is dropped
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_WRITE_DISABLE);
        host_u.frame({`OP_WRITE_STATUS, 24'h7C4000}, 3, rx);
        chk_all();
        wrs(1'b0, 8'h00, 8'h08, 8'h00, 2);
        wrs(1'b0, 8'h00, 8'h00, 8'h00, 2);
        chk_all();
        cmd(`OP_SUSPEND);
        suspend_flag = 1'b1;
        chk_all();
        cmd(`OP_RESUME);
        suspend_flag = 1'b0;
        chk_all();
        cmd(`OP_SUSPEND);
        power_cycle();
        chk_all();
        // Hardware mode: pin low locks, config stays writable
        wrs(1'b0, 8'h80, 8'h00, 8'h00, 2);
        @(posedge core_clk) #1 wp_n = 1'b0;
        wrs(1'b0, 8'h9C, 8'h40, 8'h00, 2);
        wrs(1'b1, 8'h80, 8'h00, 8'h05, 3);
        chk_all();
        @(posedge core_clk) #1 wp_n = 1'b1;
        // Pin is driven by the bench, never tied, so quad enable is safe
        wrs(1'b1, 8'h88, 8'h02, 8'h05, 3);
        @(posedge core_clk) #1 wp_n = 1'b0;
        wrs(1'b1, 8'h84, 8'h02, 8'h05, 3);
        chk_all();
        wrs(1'b1, 8'h80, 8'h00, 8'h05, 3);
        @(posedge core_clk) #1 wp_n = 1'b1;
        // Lock-down, undone by software reset then by a power cycle
        for (k = 0; k < 2; k++) begin
            wrs(1'b0, 8'h00, 8'h01, 8'h00, 2);
            wrs(1'b0, 8'hFC, 8'h40, 8'h00, 2);
            chk_all();
            if (k == 0) begin
                cmd(`OP_RESET_ENABLE);
                cmd(`OP_RESET);
                model_reset();
            end else begin
                power_cycle();
            end
            chk_all();
        end
        wrs(1'b0, 8'h80, 8'h01, 8'h00, 2);
        wrs(1'b0, 8'h00, 8'h00, 8'h00, 2);
        power_cycle();
        chk_all();
        stop_test();
    end
endmodule : flash_status_protect_config_test
`default_nettype wire
